// >>> shared/nvmuc_consts.svh
// Offsets, field positions, reset values and timing counts of the NVM unlock block.
// Assumes byte-wide registers on a plain strobe port, one clock at 40 MHz.
`ifndef NVMUC_CONSTS_SVH
`define NVMUC_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define NVMUC_OFS_CONTROL 4'h0
`define NVMUC_OFS_UNLOCK 4'h1
`define NVMUC_OFS_ADDR_LO 4'h2
`define NVMUC_OFS_ADDR_HI 4'h3
`define NVMUC_OFS_DATA_LO 4'h4
`define NVMUC_OFS_DATA_HI 4'h5
`define NVMUC_OFS_IRQ_STATUS 4'h6
`define NVMUC_OFS_IRQ_MASK 4'h7
// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define NVMUC_CTL_READ 0
`define NVMUC_CTL_WRITE 1
`define NVMUC_CTL_ALLOW 2
`define NVMUC_CTL_ERROR 3
`define NVMUC_CTL_ERASE 4
`define NVMUC_CTL_LATCH 5
`define NVMUC_CTL_REGION 6
`define NVMUC_CTL_WMASK 8'h7C
// ----------------------------------------------------------------------------
// Unlock pattern, reset values, timing
// ----------------------------------------------------------------------------
`define NVMUC_KEY_FIRST 8'h55
`define NVMUC_KEY_SECOND 8'hAA
`define NVMUC_ADDR_HI_TOP 8'h80
`define NVMUC_RESET_BYTE 8'h00
`define NVMUC_PROG_TIME_US 2
`define NVMUC_CLK_MHZ 40
`define NVMUC_PROG_CYCLES (`NVMUC_PROG_TIME_US * `NVMUC_CLK_MHZ)
`define NVMUC_PROT_LIMIT 15'h0100
`endif

// >>> shared/nvmuc_pkg.sv
// Types of the NVM unlock block.
// Assumes the constants header is included where offsets are needed.
package nvmuc_pkg;
    // ------------------------------------------------------------------------
    // Operation states, unlock key states and array request
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        NVMUC_IDLE = 4'b0001,
        NVMUC_READ = 4'b0010,
        NVMUC_PROG = 4'b0100,
        NVMUC_DONE = 4'b1000
    } nvmuc_state_t;

    typedef enum logic [1:0] {
        NVMUC_KEY_NONE = 2'b01,
        NVMUC_KEY_HALF = 2'b10
    } nvmuc_key_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic erase;
        logic latch_only;
        logic eeprom;
        logic [14:0] addr;
        logic [13:0] wdata;
    } nvmuc_req_t;
endpackage

// >>> core/nvmuc_unlock.sv
// Two-byte unlock sequence tracker of the NVM unlock block.
// Assumes unlock writes arrive as one-cycle strobes on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "nvmuc_consts.svh"
module nvmuc_unlock (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic key_we_i,
    input wire logic [7:0] key_i,
    input wire logic other_we_i,
    input wire logic consume_i,
    output logic armed_o,
    output logic broken_o
);
    import nvmuc_pkg::*;

    typedef struct packed {
        nvmuc_key_t key;
        logic armed;
        logic broken;
    } nvmuc_unl_t;

    nvmuc_unl_t q;
    nvmuc_unl_t next_q;

    // ------------------------------------------------------------------------
    // Sequence tracking
    // ------------------------------------------------------------------------
    // Any other register write between the two bytes breaks the sequence; the
    // armed state lasts only until the next write of any kind.
    always_comb begin
        next_q = q;
        next_q.broken = 1'b0;
        if (consume_i || other_we_i) begin
            next_q.armed = 1'b0;
        end
        if (key_we_i) begin
            next_q.armed = 1'b0;
            if (key_i == `NVMUC_KEY_FIRST) begin
                next_q.key = NVMUC_KEY_HALF;
            end else if (key_i == `NVMUC_KEY_SECOND && q.key == NVMUC_KEY_HALF) begin
                next_q.key = NVMUC_KEY_NONE;
                next_q.armed = 1'b1;
            end else begin
                next_q.key = NVMUC_KEY_NONE;
                next_q.broken = (q.key == NVMUC_KEY_HALF);
            end
        end else if (other_we_i && q.key == NVMUC_KEY_HALF) begin
            next_q.key = NVMUC_KEY_NONE;
            next_q.broken = ~consume_i;
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{key: NVMUC_KEY_NONE, armed: 1'b0, broken: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign armed_o = q.armed;
    assign broken_o = q.broken;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_ARM_NEEDS_PAIR: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(armed_o) |-> $past(key_we_i) && $past(key_i) == `NVMUC_KEY_SECOND)
        else $error("Unlock armed without second key byte.");
endmodule
`default_nettype wire

// >>> core/nvmuc_timer.sv
// Self-timing counter for program and erase operations.
// Assumes a one-cycle start pulse; done pulses once the count expires.
`timescale 1ns/1ps
`default_nettype none
`include "nvmuc_consts.svh"
module nvmuc_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    import nvmuc_pkg::*;

    typedef struct packed {
        logic [7:0] count;
        logic busy;
        logic done;
    } nvmuc_tmr_t;

    localparam logic [7:0] PROG_CYCLES = 8'(`NVMUC_PROG_CYCLES);

    nvmuc_tmr_t q;
    nvmuc_tmr_t next_q;

    // ------------------------------------------------------------------------
    // Countdown
    // ------------------------------------------------------------------------
    // A start while busy is ignored so that a running cycle cannot be cut short.
    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        if (q.busy) begin
            if (q.count == 8'h01) begin
                next_q.busy = 1'b0;
                next_q.done = 1'b1;
            end
            next_q.count = q.count - 8'h01;
        end else if (start_i) begin
            next_q.busy = 1'b1;
            next_q.count = PROG_CYCLES;
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{count: 8'h00, busy: 1'b0, done: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign busy_o = q.busy;
    assign done_o = q.done;
endmodule
`default_nettype wire

// >>> core/nvmuc_top.sv
// Register front end and sequencer of the NVM unlock block.
// Assumes a byte-wide strobe port on CLK_I and an array that answers reads in one cycle.
//
// Operation
// - Write start sets only right after the unlock pattern; otherwise nothing starts.
// - Clearing write start during a running program or erase does nothing.
// - EEPROM reads load only the low data byte; high byte stays.
// - Top bit of the high address register always reads one.
// - High data register holds word bits thirteen to eight.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "nvmuc_consts.svh"
module nvmuc_top (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WE_I,
    input wire logic RE_I,
    output logic [7:0] RDATA_O,
    output logic IRQ_O,
    output nvmuc_pkg::nvmuc_req_t ARRAY_REQ_O,
    input wire logic [13:0] ARRAY_RDATA_I,
    input wire logic PROT_DISABLE_I
);
    import nvmuc_pkg::*;

    typedef struct packed {
        nvmuc_state_t state;
        logic [7:0] ctl;
        logic [14:0] addr;
        logic [13:0] data;
        logic irq_status;
        logic irq_mask;
        logic [7:0] rdata;
        nvmuc_req_t req;
        logic prot_meta;
        logic prot_off;
    } nvmuc_regs_t;

    nvmuc_regs_t q;
    nvmuc_regs_t next_q;
    logic armed;
    logic broken;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic wr_ctl;
    logic protected_addr;
    logic [7:0] rd_mux;

    // ------------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------------
    nvmuc_unlock u_unlock (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .key_we_i(WE_I && ADDR_I == `NVMUC_OFS_UNLOCK),
        .key_i(WDATA_I),
        .other_we_i(WE_I && ADDR_I != `NVMUC_OFS_UNLOCK),
        .consume_i(wr_ctl && WDATA_I[`NVMUC_CTL_WRITE]),
        .armed_o(armed),
        .broken_o(broken)
    );

    nvmuc_timer u_timer (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .start_i(tmr_start),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    // Low addresses are protected while the region bit held before the start write selects program memory, unless the strap input lifts it.
    assign protected_addr = ~q.prot_off && ~q.ctl[`NVMUC_CTL_REGION]
                            && q.addr < `NVMUC_PROT_LIMIT;
    assign wr_ctl = WE_I && ADDR_I == `NVMUC_OFS_CONTROL;
    assign tmr_start = q.state == NVMUC_IDLE && wr_ctl && WDATA_I[`NVMUC_CTL_WRITE]
                       && armed && q.ctl[`NVMUC_CTL_ALLOW] && ~protected_addr;

    // ------------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------------
    // Reserved bits read as zero except the top address bit.
    always_comb begin
        rd_mux = `NVMUC_RESET_BYTE;
        unique case (ADDR_I)
            `NVMUC_OFS_CONTROL: rd_mux = q.ctl;
            `NVMUC_OFS_ADDR_LO: rd_mux = q.addr[7:0];
            `NVMUC_OFS_ADDR_HI: rd_mux = `NVMUC_ADDR_HI_TOP | {1'b0, q.addr[14:8]};
            `NVMUC_OFS_DATA_LO: rd_mux = q.data[7:0];
            `NVMUC_OFS_DATA_HI: rd_mux = {2'b00, q.data[13:8]};
            `NVMUC_OFS_IRQ_STATUS: rd_mux = {7'h00, q.irq_status};
            `NVMUC_OFS_IRQ_MASK: rd_mux = {7'h00, q.irq_mask};
            default: rd_mux = `NVMUC_RESET_BYTE;
        endcase
    end

    // ------------------------------------------------------------------------
    // Register writes and sequencer
    // ------------------------------------------------------------------------
    // Hardware events are applied after software writes so a set wins a clear.
    always_comb begin
        next_q = q;
        // The strap pin is asynchronous, so it passes two flip-flops first.
        next_q.prot_meta = PROT_DISABLE_I;
        next_q.prot_off = q.prot_meta;
        next_q.req.rd = 1'b0;
        next_q.req.wr = 1'b0;
        next_q.rdata = RE_I ? rd_mux : `NVMUC_RESET_BYTE;
        if (WE_I) begin
            unique case (ADDR_I)
                `NVMUC_OFS_CONTROL: begin
                    next_q.ctl = (q.ctl & ~`NVMUC_CTL_WMASK) | (WDATA_I & `NVMUC_CTL_WMASK);
                    // Start bits are set-only; zero writes leave them alone.
                    if (WDATA_I[`NVMUC_CTL_READ] && q.state == NVMUC_IDLE) begin
                        next_q.ctl[`NVMUC_CTL_READ] = 1'b1;
                        next_q.state = NVMUC_READ;
                        next_q.req.rd = 1'b1;
                    end
                end
                `NVMUC_OFS_ADDR_LO: next_q.addr[7:0] = WDATA_I;
                `NVMUC_OFS_ADDR_HI: next_q.addr[14:8] = WDATA_I[6:0];
                `NVMUC_OFS_DATA_LO: next_q.data[7:0] = WDATA_I;
                `NVMUC_OFS_DATA_HI: next_q.data[13:8] = WDATA_I[5:0];
                `NVMUC_OFS_IRQ_STATUS: next_q.irq_status = q.irq_status & ~WDATA_I[0];
                `NVMUC_OFS_IRQ_MASK: next_q.irq_mask = WDATA_I[0];
                default: ;
            endcase
        end
        // The request carries the settings written together with a start bit.
        next_q.req.addr = next_q.addr;
        next_q.req.wdata = next_q.data;
        next_q.req.eeprom = next_q.ctl[`NVMUC_CTL_REGION];
        next_q.req.erase = next_q.ctl[`NVMUC_CTL_ERASE];
        next_q.req.latch_only = next_q.ctl[`NVMUC_CTL_LATCH];
        if (tmr_start) begin
            next_q.ctl[`NVMUC_CTL_WRITE] = 1'b1;
            next_q.state = NVMUC_PROG;
            next_q.req.wr = 1'b1;
        end else if (wr_ctl && WDATA_I[`NVMUC_CTL_WRITE] && q.state == NVMUC_IDLE) begin
            if (protected_addr || !armed) begin
                next_q.ctl[`NVMUC_CTL_ERROR] = 1'b1;
            end
        end
        if (broken) begin
            next_q.ctl[`NVMUC_CTL_ERROR] = 1'b1;
        end
        unique case (q.state)
            NVMUC_IDLE: ;
            NVMUC_READ: begin
                // The array word is captured in the same cycle as the rd request pulse.
                next_q.data[7:0] = ARRAY_RDATA_I[7:0];
                if (!q.ctl[`NVMUC_CTL_REGION]) begin
                    next_q.data[13:8] = ARRAY_RDATA_I[13:8];
                end
                next_q.ctl[`NVMUC_CTL_READ] = 1'b0;
                next_q.state = NVMUC_DONE;
            end
            NVMUC_PROG: begin
                next_q.ctl[`NVMUC_CTL_WRITE] = 1'b1;
                if (tmr_done) begin
                    next_q.ctl[`NVMUC_CTL_WRITE] = 1'b0;
                    next_q.state = NVMUC_DONE;
                end
            end
            NVMUC_DONE: begin
                next_q.irq_status = 1'b1;
                next_q.state = NVMUC_IDLE;
            end
            default: next_q.state = NVMUC_IDLE;
        endcase
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            q <= '{state: NVMUC_IDLE, ctl: `NVMUC_RESET_BYTE, addr: 15'h0000,
                   data: 14'h0000, irq_status: 1'b0, irq_mask: 1'b0,
                   rdata: `NVMUC_RESET_BYTE, req: '0, prot_meta: 1'b0,
                   prot_off: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign RDATA_O = q.rdata;
    assign IRQ_O = q.irq_status & q.irq_mask;
    assign ARRAY_REQ_O = q.req;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_WR_NEEDS_UNLOCK: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(q.ctl[`NVMUC_CTL_WRITE]) |-> $past(armed))
        else $error("Write start set without unlock.");
    AST_WR_HOLDS: assert property (@(posedge CLK_I) disable iff (RST_I)
        q.state == NVMUC_PROG && !tmr_done |=> q.ctl[`NVMUC_CTL_WRITE])
        else $error("Write start dropped during operation.");
    AST_RD_CLEARS: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(q.ctl[`NVMUC_CTL_READ]) |=> !q.ctl[`NVMUC_CTL_READ])
        else $error("Read start not cleared after read.");
    AST_RD_LOADS: assert property (@(posedge CLK_I) disable iff (RST_I)
        q.state == NVMUC_READ |=> q.data[7:0] == $past(ARRAY_RDATA_I[7:0]))
        else $error("Read did not load low data byte.");
    AST_EE_KEEPS_HIGH: assert property (@(posedge CLK_I) disable iff (RST_I)
        q.state == NVMUC_READ && q.ctl[`NVMUC_CTL_REGION] |=> $stable(q.data[13:8]))
        else $error("EEPROM read changed high data byte.");
    AST_ADDR_TOP_ONE: assert property (@(posedge CLK_I) disable iff (RST_I)
        RE_I && ADDR_I == `NVMUC_OFS_ADDR_HI |=> RDATA_O[7])
        else $error("Top address bit read as zero.");
    AST_DATA_HI_ZERO: assert property (@(posedge CLK_I) disable iff (RST_I)
        RE_I && ADDR_I == `NVMUC_OFS_DATA_HI |=> RDATA_O[7:6] == 2'b00)
        else $error("High data reserved bits not zero.");
    AST_PROT_ERROR: assert property (@(posedge CLK_I) disable iff (RST_I)
        wr_ctl && WDATA_I[`NVMUC_CTL_WRITE] && q.state == NVMUC_IDLE && protected_addr
        |=> q.ctl[`NVMUC_CTL_ERROR] && q.state == NVMUC_IDLE)
        else $error("Protected write did not flag error.");
    AST_WR_FINISHES: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(q.ctl[`NVMUC_CTL_WRITE]) |-> ##[80:82] !q.ctl[`NVMUC_CTL_WRITE])
        else $error("Write did not finish in time.");
    COV_READ: cover property (@(posedge CLK_I) q.state == NVMUC_READ);
    COV_PROG: cover property (@(posedge CLK_I) q.state == NVMUC_PROG);
    COV_ERROR: cover property (@(posedge CLK_I) $rose(q.ctl[`NVMUC_CTL_ERROR]));
    COV_IRQ: cover property (@(posedge CLK_I) $rose(IRQ_O));
endmodule
`default_nettype wire

// >>> dv/nvmuc_array_model.sv
// Behavioural model of the flash and EEPROM array behind the NVM unlock block.
// Assumes one-cycle rd and wr pulses; a read word stands only while rd is high.
`timescale 1ns/1ps
`default_nettype none
module nvmuc_array_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire nvmuc_pkg::nvmuc_req_t req_i,
    output logic [13:0] rdata_o
);
    import nvmuc_pkg::*;
    // ------------------------------------------------------------------------
    // Storage and answer
    // ------------------------------------------------------------------------
    logic [13:0] mem [0:511];
    logic [13:0] noise;

    // Preload every word with an address pattern that the bench can predict.
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = {i[5:0], ~i[7:0]};
        end
    end

    // The word stands in the cycle of the rd pulse; outside it the bus flips every
    // cycle, so a sample taken a cycle late fails.
    assign rdata_o = (req_i.rd === 1'b1) ? mem[{req_i.eeprom, req_i.addr[7:0]}] : noise;
    always @(posedge clk_i) begin
        if (rst_i) begin
            noise <= 14'h0000;
        end else begin
            noise <= ~noise;
        end
        // Erase leaves the word at all ones; a latch-only load touches nothing.
        if (req_i.wr === 1'b1 && req_i.latch_only !== 1'b1) begin
            mem[{req_i.eeprom, req_i.addr[7:0]}] <= req_i.erase ? 14'h3FFF : req_i.wdata;
        end
    end
endmodule
`default_nettype wire

// >>> dv/nvmuc_test.sv
// Self-checking bench of the NVM unlock block with an array model behind it.
// Assumes the constants header on the include path and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "nvmuc_consts.svh"
module nvmuc_test;
    import nvmuc_pkg::*;
    // ------------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------------
    localparam logic [3:0] CTL = `NVMUC_OFS_CONTROL;
    localparam logic [3:0] KEY = `NVMUC_OFS_UNLOCK;
    localparam logic [3:0] ALO = `NVMUC_OFS_ADDR_LO;
    localparam logic [3:0] AHI = `NVMUC_OFS_ADDR_HI;
    localparam logic [3:0] DLO = `NVMUC_OFS_DATA_LO;
    localparam logic [3:0] DHI = `NVMUC_OFS_DATA_HI;
    localparam logic [3:0] IST = `NVMUC_OFS_IRQ_STATUS;
    localparam logic [3:0] IMK = `NVMUC_OFS_IRQ_MASK;
    logic CLK_I, RST_I, WE_I, RE_I, IRQ_O, PROT_DISABLE_I;
    logic [3:0] ADDR_I;
    logic [7:0] WDATA_I, RDATA_O;
    logic [13:0] ARRAY_RDATA_I;
    nvmuc_req_t ARRAY_REQ_O, last_wr, last_rd;
    int fails = 0, checks_done = 0, cycles = 0, wr_count = 0, wr_cycle = 0;

    nvmuc_top uut (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
        .ARRAY_REQ_O(ARRAY_REQ_O), .ARRAY_RDATA_I(ARRAY_RDATA_I),
        .PROT_DISABLE_I(PROT_DISABLE_I));
    nvmuc_array_model arr (.clk_i(CLK_I), .rst_i(RST_I), .req_i(ARRAY_REQ_O),
        .rdata_o(ARRAY_RDATA_I));

    always #12.5 CLK_I = ~CLK_I;

    // Records array pulses and cuts a hang short well past the longest scenario.
    always @(posedge CLK_I) begin
        cycles <= cycles + 1;
        if (ARRAY_REQ_O.wr === 1'b1) begin
            wr_count <= wr_count + 1;
            last_wr <= ARRAY_REQ_O;
            wr_cycle <= cycles;
        end
        if (ARRAY_REQ_O.rd === 1'b1) begin
            last_rd <= ARRAY_REQ_O;
        end
        if (cycles == 6000) begin
            fails = fails + 1;
            wrap_up();
        end
    end
    // ------------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        WE_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge CLK_I);
        WE_I <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just there.
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge CLK_I);
        RE_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLK_I);
        RE_I <= 1'b0;
        #1 v = RDATA_O;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rd(a, v);
        chk(what, 16'(v), 16'(exp));
    endtask
    task automatic wait_idle(input int b);
        logic [7:0] v;
        v = 8'hFF;
        for (int n = 0; n < 300 && v[b] !== 1'b0; n++) rd(CTL, v);
        chk("start bit", 16'(v[b]), 16'h0000);
    endtask
    task automatic unlock_go(input logic [7:0] c);
        wr(KEY, `NVMUC_KEY_FIRST);
        wr(KEY, `NVMUC_KEY_SECOND);
        wr(CTL, c);
    endtask
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_regs;
        rdchk(AHI, 8'h80, "addr high reset");
        rdchk(ALO, 8'h00, "addr low reset");
        wr(AHI, 8'h7F);
        rdchk(AHI, 8'hFF, "addr high top");
        rdchk(KEY, 8'h00, "unlock reads");
        wr(4'h8, 8'h5A);
        rdchk(4'h8, 8'h00, "unmapped");
        wr(DHI, 8'hFF);
        rdchk(DHI, 8'h3F, "data high width");
    endtask
    task automatic t_read;
        wr(ALO, 8'h23);
        wr(AHI, 8'h01);
        wr(CTL, 8'h01);
        wait_idle(0);
        chk("read addr", 16'(last_rd.addr), 16'h0123);
        rdchk(DLO, 8'hDC, "read low");
        rdchk(DHI, 8'h23, "read high");
    endtask
    // EEPROM read keeps a high byte that differs from the stored word.
    task automatic t_eeprom;
        wr(DHI, 8'h2A);
        wr(ALO, 8'h45);
        wr(CTL, 8'h41);
        wait_idle(0);
        chk("eeprom req", 16'(last_rd.eeprom), 16'h0001);
        rdchk(DLO, 8'hBA, "eeprom low");
        rdchk(DHI, 8'h2A, "eeprom high kept");
    endtask
    task automatic t_write;
        int n;
        n = wr_count;
        wr(IMK, 8'h01);
        wr(ALO, 8'h00);
        wr(AHI, 8'h02);
        wr(DLO, 8'hBC);
        wr(DHI, 8'h2A);
        wr(CTL, 8'h04);
        unlock_go(8'h06);
        rdchk(CTL, 8'h06, "write start set");
        wr(CTL, 8'h04);
        rdchk(CTL, 8'h06, "write start held");
        chk("one write", 16'(wr_count - n), 16'h0001);
        chk("write addr", 16'(last_wr.addr), 16'h0200);
        chk("write word", 16'(last_wr.wdata), 16'h2ABC);
        wait_idle(1);
        chk("self timed", 16'(cycles - wr_cycle >= `NVMUC_PROG_CYCLES - 4), 16'h0001);
        rdchk(CTL, 8'h04, "no error");
        rdchk(IST, 8'h01, "done flag");
        chk("irq high", 16'(IRQ_O), 16'h0001);
        wr(IST, 8'h01);
        rdchk(IST, 8'h00, "done cleared");
        chk("irq low", 16'(IRQ_O), 16'h0000);
        wr(CTL, 8'h01);
        wait_idle(0);
        rdchk(DLO, 8'hBC, "readback low");
        rdchk(DHI, 8'h2A, "readback high");
    endtask
    task automatic t_mask;
        wr(IST, 8'h01);
        wr(IMK, 8'h00);
        wr(CTL, 8'h01);
        wait_idle(0);
        rdchk(IST, 8'h01, "masked flag");
        chk("irq masked", 16'(IRQ_O), 16'h0000);
        wr(IMK, 8'h01);
        rdchk(IMK, 8'h01, "mask reg");
        chk("irq unmasked", 16'(IRQ_O), 16'h0001);
        wr(IST, 8'h01);
        rdchk(IST, 8'h00, "flag cleared");
    endtask
    // Refused starts: no key, a broken key, a protected address.
    task automatic t_refuse;
        int n;
        n = wr_count;
        wr(CTL, 8'h06);
        rdchk(CTL, 8'h0C, "start without key");
        wr(CTL, 8'h04);
        rdchk(CTL, 8'h04, "error cleared");
        wr(KEY, `NVMUC_KEY_FIRST);
        wr(ALO, 8'h10);
        rdchk(CTL, 8'h0C, "interrupted key");
        wr(KEY, `NVMUC_KEY_SECOND);
        wr(CTL, 8'h06);
        rdchk(CTL, 8'h0C, "broken key");
        wr(AHI, 8'h00);
        wr(CTL, 8'h04);
        unlock_go(8'h06);
        rdchk(CTL, 8'h0C, "protected");
        wr(CTL, 8'h04);
        chk("no write", 16'(wr_count - n), 16'h0000);
        PROT_DISABLE_I <= 1'b1;
        unlock_go(8'h16);
        rdchk(CTL, 8'h16, "protection lifted");
        wait_idle(1);
        chk("lifted addr", 16'(last_wr.addr), 16'h0010);
        chk("erase req", 16'(last_wr.erase), 16'h0001);
        PROT_DISABLE_I <= 1'b0;
    endtask
    task automatic wrap_up;
        if (fails == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset for 16 cycles, then run every scenario once.
    initial begin
        CLK_I = 1'b0;
        RST_I = 1'b1;
        WE_I = 1'b0;
        RE_I = 1'b0;
        ADDR_I = 4'h0;
        WDATA_I = 8'h00;
        PROT_DISABLE_I = 1'b0;
        repeat (16) @(posedge CLK_I);
        RST_I <= 1'b0;
        t_regs();
        t_read();
        t_eeprom();
        t_write();
        t_mask();
        t_refuse();
        wrap_up();
    end
endmodule
`default_nettype wire
